/* File: hdl/ptsc_top.sv */
// ptsc_top: setup and control front end of a 16-bit pwm timer
// assumes: compare logic outside supplies the duty windows and reads the count
`default_nettype none

module ptsc_top (
  // clock, reset, enable
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_ce,
  // axi4-lite write channels
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [ptsc_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // axi4-lite read channels
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [ptsc_pkg::ADDR_W-1:0] i_araddr,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  // compare side
  input  wire logic [1:0]                  i_duty_active,
  output logic [15:0]                      o_count,
  output logic [1:0]                       o_op_mode,
  // timer outputs and interrupt
  output logic                             o_pwm_output_a,
  output logic                             o_pwm_output_b,
  output logic                             o_irq
);

  ptsc_pkg::ptsc_wreq_s        wreq;
  ptsc_pkg::ptsc_state_e       state;
  ptsc_pkg::ptsc_state_e       next_state;
  ptsc_pkg::ptsc_opctl_s       opctl;
  ptsc_pkg::ptsc_opctl_s       next_opctl;
  ptsc_pkg::ptsc_opctl_s       op_in;
  ptsc_pkg::ptsc_outctl_s      outctl;
  ptsc_pkg::ptsc_outctl_s      next_outctl;
  logic                        timer_reset_hold;
  logic                        timer_clock_gate_enable;
  logic [2:0]                  psc_a_sel;
  logic [2:0]                  psc_b_sel;
  logic                        timer_irq_flag;
  logic                        timer_irq_mask;
  logic [15:0]                 count;
  logic [15:0]                 next_count;
  logic [1:0]                  next_pwm;
  logic                        tick_a;
  logic                        tick_b;
  logic                        sel_tick;
  logic                        timer_wr_ok;
  logic                        irq_evt;
  logic                        irq_clr;
  logic [ptsc_pkg::ADDR_W-1:0] rd_addr;
  logic [15:0]                 rd_data;
  logic                        rd_hit;
  logic                        wr_hit;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [2:0] psc_pick(input logic [2:0] nv, input logic [2:0] ov);
    return (nv <= ptsc_pkg::PSC_MAX_CODE) ? nv : ov;
  endfunction

  function automatic logic drive_level(input logic act, input logic tol, input logic tod);
    return act ? !tol : tod;
  endfunction

  ptsc_axil_slave u_bus (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .o_bresp   (o_bresp),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .i_araddr  (i_araddr),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_wreq    (wreq),
    .i_wr_hit  (wr_hit),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_hit  (rd_hit)
  );

  ptsc_prescaler #(
    .CNT_W (5),
    .SEL_W (3)
  ) u_psc (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_ce     (i_ce),
    .i_sel_a  (psc_a_sel),
    .i_sel_b  (psc_b_sel),
    .o_tick_a (tick_a),
    .o_tick_b (tick_b)
  );

  // write decode
  wire wr_rst = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_RESET_CTRL);
  wire wr_cge = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_CLK_ENABLE);
  wire wr_psc = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_PRESCALER);
  wire wr_ifl = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_IRQ_FLAGS);
  wire wr_msk = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_IRQ_MASK);
  wire wr_opc = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_OP_CTRL);
  wire wr_out = wreq.en && hit(wreq.addr, ptsc_pkg::OFS_OUT_LEVEL);

  assign wr_hit = wreq.addr <= ptsc_pkg::OFS_COUNT && wreq.addr[1:0] == 2'b00;
  assign rd_hit = rd_addr <= ptsc_pkg::OFS_COUNT && rd_addr[1:0] == 2'b00;

  assign rd_data =
      hit(rd_addr, ptsc_pkg::OFS_RESET_CTRL) ? {15'h0000, timer_reset_hold} :
      hit(rd_addr, ptsc_pkg::OFS_CLK_ENABLE) ? {15'h0000, timer_clock_gate_enable} :
      hit(rd_addr, ptsc_pkg::OFS_PRESCALER)  ? {9'h000, psc_b_sel, 1'b0, psc_a_sel} :
      hit(rd_addr, ptsc_pkg::OFS_IRQ_FLAGS)  ? {10'h000, timer_irq_flag, 5'h00} :
      hit(rd_addr, ptsc_pkg::OFS_IRQ_MASK)   ? {10'h000, timer_irq_mask, 5'h00} :
      hit(rd_addr, ptsc_pkg::OFS_OP_CTRL)    ? {8'h00, opctl} :
      hit(rd_addr, ptsc_pkg::OFS_OUT_LEVEL)  ? {8'h00, outctl} :
      hit(rd_addr, ptsc_pkg::OFS_COUNT)      ? count : 16'h0000;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_reset_hold        <= ptsc_pkg::RST_RESET_HOLD;
      timer_clock_gate_enable <= ptsc_pkg::RST_CLK_GATE;
    end else if (i_ce) begin
      if (wr_rst) begin
        timer_reset_hold <= wreq.data[ptsc_pkg::RESET_HOLD_BIT];
      end
      if (wr_cge) begin
        timer_clock_gate_enable <= wreq.data[ptsc_pkg::CLK_GATE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      psc_a_sel <= ptsc_pkg::RST_PSC;
      psc_b_sel <= ptsc_pkg::RST_PSC;
    end else if (i_ce && wr_psc) begin
      psc_a_sel <= psc_pick(wreq.data[ptsc_pkg::PSC_A_LSB +: 3], psc_a_sel);
      psc_b_sel <= psc_pick(wreq.data[ptsc_pkg::PSC_B_LSB +: 3], psc_b_sel);
    end
  end

  assign irq_evt = state == ptsc_pkg::ST_RUNNING && sel_tick &&
                   count == ptsc_pkg::COUNT_LAST_STEP;
  assign irq_clr = wr_ifl && wreq.data[ptsc_pkg::IRQ_BIT];
  assign o_irq   = timer_irq_flag && !timer_irq_mask;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_irq_flag <= ptsc_pkg::RST_IRQ_FLAG;
      timer_irq_mask <= ptsc_pkg::RST_IRQ_MASK;
    end else if (i_ce) begin
      timer_irq_flag <= irq_evt || (timer_irq_flag && !irq_clr);
      if (wr_msk) begin
        timer_irq_mask <= wreq.data[ptsc_pkg::IRQ_BIT];
      end
    end
  end

  assign timer_wr_ok = timer_clock_gate_enable && !timer_reset_hold;

  assign op_in = ptsc_pkg::ptsc_opctl_s'(wreq.data);
  wire mode_ok = op_in.mode == ptsc_pkg::MODE_STANDALONE ||
                 op_in.mode == ptsc_pkg::MODE_INTERLEAVE;

  assign next_opctl =
      timer_reset_hold ? ptsc_pkg::RST_OPCTL :
      (wr_opc && timer_wr_ok) ? ptsc_pkg::ptsc_opctl_s'{run: op_in.run, pad_hi: 2'b00,
          cksel: op_in.cksel, pad_lo: 2'b00, mode: mode_ok ? op_in.mode : opctl.mode} :
      opctl;

  assign next_outctl =
      timer_reset_hold ? ptsc_pkg::RST_OUTCTL :
      (wr_out && timer_wr_ok) ? ptsc_pkg::ptsc_outctl_s'({4'h0, wreq.data[3:0]}) :
      outctl;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      opctl  <= ptsc_pkg::RST_OPCTL;
      outctl <= ptsc_pkg::RST_OUTCTL;
    end else if (i_ce) begin
      opctl  <= next_opctl;
      outctl <= next_outctl;
    end
  end

  assign o_op_mode = opctl.mode;

  assign sel_tick = opctl.cksel ? tick_b : tick_a;

  always_comb begin
    if (timer_reset_hold) begin
      next_state = ptsc_pkg::ST_HELD;
    end else if (!timer_clock_gate_enable) begin
      next_state = ptsc_pkg::ST_GATED;
    end else if (!opctl.run) begin
      next_state = ptsc_pkg::ST_STOPPED;
    end else begin
      next_state = ptsc_pkg::ST_RUNNING;
    end
  end

  always_comb begin
    case (state)
      ptsc_pkg::ST_RUNNING: next_count = sel_tick ? count + ptsc_pkg::COUNT_STEP : count;
      ptsc_pkg::ST_GATED:   next_count = count;
      default:              next_count = ptsc_pkg::COUNTER_STOP;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ptsc_pkg::ST_HELD;
      count <= ptsc_pkg::COUNTER_STOP;
    end else if (i_ce) begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign o_count = count;

  wire run_now = state == ptsc_pkg::ST_RUNNING;
  wire b_duty  = (opctl.mode == ptsc_pkg::MODE_INTERLEAVE) ? i_duty_active[1] : i_duty_active[0];
  assign next_pwm[0] = drive_level(run_now && i_duty_active[0], outctl.tol[0], outctl.tod[0]);
  assign next_pwm[1] = drive_level(run_now && b_duty, outctl.tol[1], outctl.tod[1]);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pwm_output_a <= ptsc_pkg::RST_PWM_LEVEL;
      o_pwm_output_b <= ptsc_pkg::RST_PWM_LEVEL;
    end else if (i_ce) begin
      o_pwm_output_a <= next_pwm[0];
      o_pwm_output_b <= next_pwm[1];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_hold_state;
    i_ce && timer_reset_hold |=> state == ptsc_pkg::ST_HELD;
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("hold did not stop timer");

  property p_hold_count;
    i_ce && state == ptsc_pkg::ST_HELD |=> count == ptsc_pkg::COUNTER_STOP && opctl == 8'h00;
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("held timer not cleared");

  property p_gated_freeze;
    state == ptsc_pkg::ST_GATED ##1 state == ptsc_pkg::ST_GATED |-> $stable(count);
  endproperty
  a_gated_freeze: assert property (p_gated_freeze) else $error("gated counter moved");

  property p_gated_write;
    i_ce && wr_opc && !timer_clock_gate_enable && !timer_reset_hold |=> $stable(opctl);
  endproperty
  a_gated_write: assert property (p_gated_write) else $error("write taken while gated");

  property p_clk_select;
    i_ce && run_now && opctl.cksel && !tick_b |=> $stable(count);
  endproperty
  a_clk_select: assert property (p_clk_select) else $error("counted on wrong clock");

  property p_count_step;
    i_ce && run_now && sel_tick |=> count == $past(count) + ptsc_pkg::COUNT_STEP;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed a step");

  property p_stopped_load;
    i_ce && state == ptsc_pkg::ST_STOPPED |=> count == ptsc_pkg::COUNTER_STOP;
  endproperty
  a_stopped_load: assert property (p_stopped_load) else $error("stop did not load ones");

  property p_irq_set;
    i_ce && irq_evt |=> timer_irq_flag ##0 (o_irq == !timer_irq_mask);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt event lost");

  property p_mode_keep;
    i_ce && wr_opc && timer_wr_ok && !mode_ok |=> $stable(opctl.mode);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("prohibited mode taken");

  property p_active_level;
    i_ce && run_now && i_duty_active[0] && outctl.tol[0] |=> !o_pwm_output_a;
  endproperty
  a_active_level: assert property (p_active_level) else $error("active low not driven");

  property p_default_level;
    i_ce && !run_now && outctl.tod[1] |=> o_pwm_output_b;
  endproperty
  a_default_level: assert property (p_default_level) else $error("default high not driven");

  c_running: cover property (state == ptsc_pkg::ST_RUNNING && sel_tick);
  c_irq: cover property (i_ce && irq_evt ##1 o_irq);
  c_interleave: cover property (run_now && opctl.mode == ptsc_pkg::MODE_INTERLEAVE);
  c_set_over_clear: cover property (i_ce && irq_evt && irq_clr);

endmodule

`default_nettype wire

/* File: hdl/ptsc_pkg.sv */
// ptsc_pkg: offsets, fields, reset values and types of the pwm timer setup block
// assumes: AXI4-Lite access with 32-bit data, each register in the low bits of a word
`default_nettype none

package ptsc_pkg;

  localparam int unsigned ADDR_W = 6;

  // register byte offsets
  localparam logic [5:0] OFS_RESET_CTRL = 6'h00;
  localparam logic [5:0] OFS_CLK_ENABLE = 6'h04;
  localparam logic [5:0] OFS_PRESCALER  = 6'h08;
  localparam logic [5:0] OFS_IRQ_FLAGS  = 6'h0C;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h10;
  localparam logic [5:0] OFS_OP_CTRL    = 6'h14;
  localparam logic [5:0] OFS_OUT_LEVEL  = 6'h18;
  localparam logic [5:0] OFS_COUNT      = 6'h1C;

  // field positions
  localparam int unsigned RESET_HOLD_BIT = 0;
  localparam int unsigned CLK_GATE_BIT   = 0;
  localparam int unsigned PSC_A_LSB      = 0;
  localparam int unsigned PSC_B_LSB      = 4;
  localparam int unsigned IRQ_BIT        = 5;

  // values after reset
  localparam logic        RST_RESET_HOLD = 1'b1;
  localparam logic        RST_CLK_GATE   = 1'b0;
  localparam logic [2:0]  RST_PSC        = 3'h0;
  localparam logic        RST_IRQ_FLAG   = 1'b0;
  localparam logic        RST_IRQ_MASK   = 1'b1;
  localparam logic        RST_PWM_LEVEL  = 1'b0;

  // counter and codes
  localparam logic [15:0] COUNTER_STOP    = 16'hFFFF;
  localparam logic [15:0] COUNT_LAST_STEP = 16'hFFFE;
  localparam logic [15:0] COUNT_STEP      = 16'h0001;
  localparam logic [2:0]  PSC_MAX_CODE    = 3'h5;
  localparam logic [1:0]  MODE_STANDALONE = 2'h0;
  localparam logic [1:0]  MODE_INTERLEAVE = 2'h3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    ST_HELD    = 4'b0001,
    ST_GATED   = 4'b0010,
    ST_STOPPED = 4'b0100,
    ST_RUNNING = 4'b1000
  } ptsc_state_e;

  typedef struct packed {
    logic       run;
    logic [1:0] pad_hi;
    logic       cksel;
    logic [1:0] pad_lo;
    logic [1:0] mode;
  } ptsc_opctl_s;

  typedef struct packed {
    logic [3:0] pad;
    logic [1:0] tol;
    logic [1:0] tod;
  } ptsc_outctl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              en;
  } ptsc_wreq_s;

  localparam ptsc_opctl_s  RST_OPCTL  = ptsc_opctl_s'(8'h00);
  localparam ptsc_outctl_s RST_OUTCTL = ptsc_outctl_s'(8'h00);

endpackage

`default_nettype wire

/* File: hdl/ptsc_prescaler.sv */
// ptsc_prescaler: free divider giving two clock-enable ticks at fclk/2^sel
// assumes: sel codes above the maximum are filtered by the register logic
`default_nettype none

module ptsc_prescaler #(
  parameter int unsigned CNT_W = 5,
  parameter int unsigned SEL_W = 3
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  // divider selects
  input  wire logic [SEL_W-1:0] i_sel_a,
  input  wire logic [SEL_W-1:0] i_sel_b,
  // ticks
  output logic                  o_tick_a,
  output logic                  o_tick_b
);

  logic [CNT_W-1:0] div_cnt;

  function automatic logic tick_of(input logic [CNT_W-1:0] cnt, input logic [SEL_W-1:0] sel);
    logic [CNT_W-1:0] m;
    m = CNT_W'((32'd1 << sel) - 32'd1);
    return (cnt & m) == m;
  endfunction

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_cnt <= '0;
    end else if (i_ce) begin
      div_cnt <= div_cnt + CNT_W'(1);
    end
  end

  assign o_tick_a = tick_of(div_cnt, i_sel_a);
  assign o_tick_b = tick_of(div_cnt, i_sel_b);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_div1;
    i_sel_a == 3'h0 |-> o_tick_a;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a tick");

  property p_div2;
    o_tick_a && i_ce && i_sel_a == 3'h1 ##1 i_sel_a == 3'h1 |-> !o_tick_a;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice");

endmodule

`default_nettype wire

/* File: hdl/ptsc_axil_slave.sv */
// ptsc_axil_slave: AXI4-Lite slave turning bus traffic into byte writes and 16-bit reads
// assumes: the owner decodes addresses and returns read data combinationally
`default_nettype none

module ptsc_axil_slave (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_ce,
  // write channels
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [ptsc_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // read channels
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [ptsc_pkg::ADDR_W-1:0] i_araddr,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  // register side
  output ptsc_pkg::ptsc_wreq_s             o_wreq,
  input  wire logic                        i_wr_hit,
  output logic [ptsc_pkg::ADDR_W-1:0]      o_rd_addr,
  input  wire logic [15:0]                 i_rd_data,
  input  wire logic                        i_rd_hit
);

  logic                        aw_full;
  logic                        w_full;
  logic [ptsc_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0]                  w_data;
  logic                        w_lane0;

  wire aw_take = o_awready && i_awvalid;
  wire w_take  = o_wready && i_wvalid;
  wire wr_fire = i_ce && aw_full && w_full && !o_bvalid;
  wire ar_take = o_arready && i_arvalid;

  assign o_awready = i_ce && !aw_full && !o_bvalid;
  assign o_wready  = i_ce && !w_full && !o_bvalid;
  assign o_arready = i_ce && !o_rvalid;
  assign o_rd_addr = i_araddr;
  assign o_wreq    = '{addr: aw_addr, data: w_data, en: wr_fire && w_lane0};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_full <= 1'b1;
      aw_addr <= i_awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      w_full  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_full  <= 1'b1;
      w_data  <= i_wdata[7:0];
      w_lane0 <= i_wstrb[0];
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bvalid <= 1'b0;
      o_bresp  <= ptsc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= i_wr_hit ? ptsc_pkg::RESP_OKAY : ptsc_pkg::RESP_SLVERR;
    end else if (i_ce && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= ptsc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {16'h0000, i_rd_data};
      o_rresp  <= i_rd_hit ? ptsc_pkg::RESP_OKAY : ptsc_pkg::RESP_SLVERR;
    end else if (i_ce && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: bench/ptsc_power_stage.sv */
// ptsc_power_stage: far-side model, a gate driver latching both pwm legs
// assumes: legs are plain levels sampled on the system clock
`default_nettype none
module ptsc_power_stage (
  // clock
  input  wire logic i_clk,
  // pwm legs
  input  wire logic i_leg_a,
  input  wire logic i_leg_b,
  // switch gates
  output logic      o_gate_a,
  output logic      o_gate_b
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_clk) begin
    o_gate_a <= i_leg_a;
    o_gate_b <= i_leg_b;
  end
endmodule
`default_nettype wire

/* File: bench/pwm_timer_setup_control_bench.sv */
// pwm_timer_setup_control_bench: random and corner tests of ptsc_top
// assumes: ptsc_pkg and ptsc_top compiled first
`default_nettype none
module pwm_timer_setup_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] OP = ptsc_pkg::OFS_OP_CTRL;
  localparam logic [5:0] CE = ptsc_pkg::OFS_CLK_ENABLE;
  localparam logic [5:0] PS = ptsc_pkg::OFS_PRESCALER;
  localparam logic [5:0] CN = ptsc_pkg::OFS_COUNT;
  logic        clk, rst, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, pa, pb, ga, gb, irq, run, m;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, c;
  logic [1:0]  duty, rresp, rr, bresp, br, mode, t, d;
  logic [15:0] count;
  logic [2:0]  a;
  int          miscompares, n_checks, cyc;

  ptsc_top dut (.i_clk(clk), .i_reset(rst), .i_ce(ce), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_duty_active(duty),
    .o_count(count), .o_op_mode(mode), .o_pwm_output_a(pa), .o_pwm_output_b(pb),
    .o_irq(irq));
  ptsc_power_stage ps (.i_clk(clk), .i_leg_a(pa), .i_leg_b(pb), .o_gate_a(ga), .o_gate_b(gb));

  function automatic logic lvl(logic r, logic w, logic tl, logic td);
    return (r && w) ? !tl : td;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
    logic da, dw, ta, tw;
    da = 0;
    dw = 0;
    @(posedge clk);
    awaddr <= ad;
    wdata <= {24'h0, dt};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = !da && awready;
      tw = !dw && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge clk); while (!bvalid);
    br = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [5:0] ad);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    {rst, ce, awvalid, wvalid, bready, arvalid, rready} = 7'b1100000;
    {awaddr, araddr, wdata, duty} = '0;
    {miscompares, n_checks, cyc} = '0;
    a = 3'($urandom(32'h10fc_882a));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdr(ptsc_pkg::OFS_RESET_CTRL); chk(rd, 32'h1);
    rdr(ptsc_pkg::OFS_IRQ_MASK); chk(rd, 32'h20);
    wr(OP, 8'h80); rdr(OP); chk(rd, 32'h0);
    wr(ptsc_pkg::OFS_RESET_CTRL, 8'h0);
    wr(CE, 8'h1);
    a = 3'($urandom_range(3, 0));
    wr(PS, {4'h5, 1'b0, a}); rdr(PS); chk(rd, {24'h0, 4'h5, 1'b0, a});
    wr(PS, 8'h56); rdr(PS); chk(rd, {24'h0, 4'h5, 1'b0, a});
    // counter on the slow divider must stay far below the fast one
    wr(OP, 8'h90);
    repeat (128) @(posedge clk);
    rdr(CN); chk(rd >> 3, 32'h0);
    wr(CE, 8'h0); rdr(CN); c = rd;
    repeat (40) @(posedge clk);
    rdr(CN); chk(rd, c);
    wr(OP, 8'h00); rdr(OP); chk(rd, 32'h90);
    chk(32'(br), 32'h0);
    wr(CE, 8'h1);
    wr(OP, 8'h00); rdr(CN); chk(rd, 32'hFFFF);
    chk(32'(count), 32'hFFFF);
    wr(OP, 8'h03); chk(32'(mode), 32'h3);
    wr(OP, 8'h01); chk(32'(mode), 32'h3);
    wr(OP, 8'h00); chk(32'(mode), 32'h0);
    repeat (8) begin
      run = 1'($urandom);
      m = 1'($urandom);
      t = 2'($urandom);
      d = 2'($urandom);
      wr(ptsc_pkg::OFS_OUT_LEVEL, {4'h0, t, d});
      wr(OP, {run, 5'h00, m, m});
      duty <= 2'($urandom);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'({pa, ga}), 32'({2{lvl(run, duty[0], t[0], d[0])}}));
      chk(32'({pb, gb}), 32'({2{lvl(run, duty[m], t[1], d[1])}}));
    end
    // full wrap at divide-by-one raises the event once
    wr(PS, 8'h00);
    wr(OP, 8'h80);
    repeat (100) @(posedge clk);
    // clock enable low must freeze the running counter
    ce <= 1'b0;
    @(negedge clk) c = 32'(count);
    repeat (20) @(negedge clk);
    chk(32'(count), c);
    @(posedge clk) ce <= 1'b1;
    repeat (65460) @(posedge clk);
    wr(OP, 8'h00);
    rdr(ptsc_pkg::OFS_IRQ_FLAGS); chk(rd, 32'h20);
    chk(32'(irq), 32'h0);
    wr(ptsc_pkg::OFS_IRQ_MASK, 8'h00); chk(32'(irq), 32'h1);
    wr(ptsc_pkg::OFS_IRQ_FLAGS, 8'h20); chk(32'(irq), 32'h0);
    wr(ptsc_pkg::OFS_RESET_CTRL, 8'h1);
    rdr(ptsc_pkg::OFS_OUT_LEVEL); chk(rd, 32'h0);
    rdr(6'h20); chk(32'(rr), 32'h2);
    wr(6'h20, 8'h00); chk(32'(br), 32'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
